// [rtl/rawf_filter.sv]
// Receive destination address filter and wake-up frame detector
//
// Summary of operation
// - Physical or multicast decided by first bit of six-byte destination.
// - Frames rejected by the filter mode are never delivered to host.
// - All bits clear: perfect filter; hash-perfect alone: multicast hashed.
// - Hash-only plus hash-perfect: all destinations checked by hash table only.
// - Inverse mode accepts destinations differing from station, rejects equal.
// - Promiscuous accepts every frame including broadcast, overriding others.
// - Pass-all-multicast accepts multicast; physical perfect or hash filtered.
// - Perfect filter needs exact match with high and low station address.
// - Hash: destination through CRC, upper six bits index 64-bit table.
// - Index top bit picks high or low word, five bits pick bit.
// - Wake-frame enable stops normal reception and looks for patterns.
// - Wake frame sets received flag; may raise interrupt or power event.
// - Host clears wake-frame enable; normal reception then resumes.
// - Four filters; wake frame passes address type and CRC match.
// - In wake mode frames addressed to station are checked against filters.
// - Mask bit j admits byte offset plus j into the CRC, 31 bytes.
// - Wake detection in full power state gated by wake-frame enable only.
// - In first low-power state wake detection is always active.
// - Matching broadcast wake frame wakes despite broadcast-disable.
// - Command bit 0 enables, bit 3 selects multicast or unicast frames.
// - Programmed 16-bit CRC equal to masked-byte CRC-16 flags a wake frame.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns

module rawf_filter
    import rawf_pkg::*;
#(
    parameter int NUM_FILTERS = RAWF_NUM_FILTERS
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_sof_in,
    input wire logic rx_eof_in,
    output logic rx_ready_out,
    input wire logic low_power_d1_in,
    output logic [7:0] host_data_out,
    output logic host_valid_out,
    output logic host_last_out,
    output logic host_irq_out,
    output logic power_event_output_out
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // The packed filter register layout only has room for four filters
    if (NUM_FILTERS != RAWF_NUM_FILTERS) begin : g_bad_filters
        $error("rawf_filter: NUM_FILTERS must be 4");
    end

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Ethernet CRC-32, reflected, one byte, least significant bit first
    function automatic logic [31:0] crc32_byte(input logic [31:0] crc, input logic [7:0] d);
        logic [31:0] c;

        c = crc;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ d[i]) begin
                c = (c >> 1) ^ RAWF_CRC32_POLY;
            end else begin
                c = c >> 1;
            end
        end
        return c;
    endfunction

    // CRC-16 used by the wake pattern filters, most significant bit first
    function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] d);
        logic [15:0] c;

        c = crc;
        for (int i = 7; i >= 0; i--) begin
            if (c[15] ^ d[i]) begin
                c = {c[14:0], 1'b0} ^ RAWF_CRC16_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction

    // Address filter decision for one destination address
    function automatic logic addr_pass(input logic [5:0] ctrl, input logic mc, input logic bc,
                                       input logic perfect, input logic hash_hit);
        logic ok;

        // Fallback for every mode
        ok = perfect;
        if (ctrl[RAWF_BIT_PROMISC]) begin
            ok = 1'b1;
        end else if (mc && ctrl[RAWF_BIT_PASS_ALL_MC]) begin
            ok = 1'b1;
        end else if (ctrl[RAWF_BIT_INVERSE]) begin
            ok = !perfect;
        end else if (ctrl[RAWF_BIT_HASH_ONLY] && ctrl[RAWF_BIT_HASH_PERFECT]) begin
            ok = hash_hit;
        end else if (ctrl[RAWF_BIT_HASH_PERFECT] && mc) begin
            ok = hash_hit;
        end

        // Broadcast passes unless disabled; promiscuous overrides the disable
        if (bc && !ctrl[RAWF_BIT_PROMISC]) begin
            ok = !ctrl[RAWF_BIT_BROADCAST_DISABLE_DIS];
        end

        return ok;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    rawf_state_s st;
    rawf_state_s next_st;

    // Working values of the combinational process
    logic [8:0] cur_idx;
    logic [31:0] hcrc_in;
    logic [31:0] hcrc_new;

    // Address decision
    logic [47:0] dest;
    logic [47:0] station;
    logic [5:0] hash_ix;
    logic hash_hit;
    logic perfect;

    // Wake working values
    logic wake_mode;
    logic wake_hit;
    logic [8:0] rel;
    logic [15:0] wcrc_in;
    logic [7:0] off;
    logic [3:0] cmd;
    logic [15:0] want;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        next_st = st;
        // Single-cycle pulses
        next_st.out_valid = 1'b0;
        next_st.out_last = 1'b0;

        // Start byte restarts count
        cur_idx = rx_sof_in ? 9'h000 : st.idx;
        hcrc_in = rx_sof_in ? RAWF_CRC32_INIT : st.hcrc;
        hcrc_new = crc32_byte(hcrc_in, rx_data_in);
        // First received byte sits in the low byte of the address
        dest = {rx_data_in, st.dline[0], st.dline[1], st.dline[2], st.dline[3], st.dline[4]};
        station = {st.addr_hi, st.addr_lo};
        hash_ix = hcrc_new[31:26];
        hash_hit = hash_ix[5] ? st.hash_hi[hash_ix[4:0]] : st.hash_lo[hash_ix[4:0]];
        perfect = (dest == station);
        // Detection is forced on in the first low-power state
        wake_mode = st.wake_en || low_power_d1_in;

        // Loop scratch defaults
        wake_hit = 1'b0;
        rel = 9'h000;
        wcrc_in = RAWF_CRC16_INIT;
        off = 8'h00;
        cmd = 4'h0;
        want = 16'h0000;

        // Register writes; a one written to the received flag clears it
        if (reg_wr_in) begin
            case (reg_addr_in)
                RAWF_OFS_MAC_CONTROL: begin
                    next_st.ctrl = reg_wdata_in[5:0];
                end
                RAWF_OFS_ADDR_HIGH: begin
                    next_st.addr_hi = reg_wdata_in[15:0];
                end
                RAWF_OFS_ADDR_LOW: begin
                    next_st.addr_lo = reg_wdata_in;
                end
                RAWF_OFS_HASH_HIGH: begin
                    next_st.hash_hi = reg_wdata_in;
                end
                RAWF_OFS_HASH_LOW: begin
                    next_st.hash_lo = reg_wdata_in;
                end
                RAWF_OFS_WAKE_CTRL: begin
                    next_st.wake_en = reg_wdata_in[RAWF_BIT_WAKE_EN];
                    next_st.irq_en = reg_wdata_in[RAWF_BIT_IRQ_EN];
                    next_st.pme_en = reg_wdata_in[RAWF_BIT_PME_EN];
                    // Write one to clear
                    if (reg_wdata_in[RAWF_BIT_WAKE_RCVD]) begin
                        next_st.wake_rcvd = 1'b0;
                    end
                    // Restart the eight-word load sequence
                    next_st.wptr = 3'h0;
                end
                RAWF_OFS_WAKE_FILTER: begin
                    next_st.wake_pattern_filter[st.wptr] = reg_wdata_in;
                    next_st.wptr = st.wptr + 3'h1;
                end
                default: begin
                end
            endcase
        end

        // Register reads, answered one cycle later; unmapped reads give zero
        if (reg_rd_in) begin
            case (reg_addr_in)
                RAWF_OFS_MAC_CONTROL: next_st.rd_data = {26'h0, st.ctrl};
                RAWF_OFS_ADDR_HIGH: next_st.rd_data = {16'h0, st.addr_hi};
                RAWF_OFS_ADDR_LOW: next_st.rd_data = st.addr_lo;
                RAWF_OFS_HASH_HIGH: next_st.rd_data = st.hash_hi;
                RAWF_OFS_HASH_LOW: next_st.rd_data = st.hash_lo;
                RAWF_OFS_WAKE_CTRL: begin
                    next_st.rd_data = {26'h0, (st.state != RAWF_IDLE), low_power_d1_in,
                                       st.pme_en, st.irq_en, st.wake_rcvd, st.wake_en};
                end
                RAWF_OFS_WAKE_FILTER: next_st.rd_data = st.wake_pattern_filter[st.wptr];
                RAWF_OFS_FRAME_STATS: next_st.rd_data = {st.drop_cnt, st.acc_cnt};
                default: next_st.rd_data = 32'h0000_0000;
            endcase
        end

        // Receive sequencing
        case (st.state)
            RAWF_IDLE, RAWF_ADDR, RAWF_BODY: begin
                if (rx_valid_in && (rx_sof_in || st.state != RAWF_IDLE)) begin
                    next_st.idx = (cur_idx == RAWF_IDX_MAX) ? cur_idx : cur_idx + 9'h001;
                    next_st.dline = {st.dline[4:0], rx_data_in};
                    if (rx_sof_in) begin
                        // Mode is frozen per frame so a mid-frame change is harmless
                        next_st.wake = wake_mode;
                        next_st.keep = 1'b0;
                        next_st.state = RAWF_ADDR;
                    end

                    // Hash covers address only
                    if (cur_idx < 9'(RAWF_DA_BYTES)) begin
                        next_st.hcrc = hcrc_new;
                    end

                    // Decision made on the last address byte, before any output
                    if (cur_idx == RAWF_IDX_LAST_DA) begin
                        next_st.mcast = rx_data_in_first_bit(rx_sof_in, rx_data_in, st.dline[4]);
                        next_st.addressed = perfect || dest[0];
                        next_st.keep = !(rx_sof_in ? wake_mode : st.wake) &&
                            addr_pass(st.ctrl, dest[0], &dest, perfect, hash_hit);
                        next_st.state = RAWF_BODY;
                    end

                    // Wake pattern CRCs over masked bytes
                    for (int f = 0; f < RAWF_NUM_FILTERS; f++) begin
                        off = st.wake_pattern_filter[RAWF_OFFSET_WORD][8*f +: 8];
                        wcrc_in = rx_sof_in ? RAWF_CRC16_INIT : st.wcrc[f];
                        rel = cur_idx - {1'b0, off};
                        if (cur_idx >= {1'b0, off} && rel < 9'(RAWF_MASK_LEN) &&
                            st.wake_pattern_filter[f][rel[4:0]]) begin
                            next_st.wcrc[f] = crc16_byte(wcrc_in, rx_data_in);
                        end else begin
                            next_st.wcrc[f] = wcrc_in;
                        end
                    end

                    // Delivery of the byte six places back
                    if (st.state == RAWF_BODY && st.keep) begin
                        next_st.out_data = st.dline[5];
                        next_st.out_valid = 1'b1;
                    end

                    if (rx_eof_in) begin
                        // Wake check at frame end for every enabled filter
                        if ((rx_sof_in ? wake_mode : st.wake) && cur_idx >= RAWF_IDX_LAST_DA &&
                            next_st.addressed) begin
                            for (int f = 0; f < RAWF_NUM_FILTERS; f++) begin
                                cmd = st.wake_pattern_filter[RAWF_CMD_WORD][8*f +: 4];
                                want = st.wake_pattern_filter[RAWF_CRC_WORD + f/2][16*(f%2) +: 16];
                                if (cmd[RAWF_CMD_ENABLE] &&
                                    cmd[RAWF_CMD_MCAST] == next_st.mcast &&
                                    next_st.wcrc[f] == want) begin
                                    wake_hit = 1'b1;
                                end
                            end
                        end

                        // Runts count as dropped
                        if (cur_idx >= RAWF_IDX_LAST_DA && next_st.keep) begin
                            next_st.flush_cnt = RAWF_FLUSH_LEN;
                            next_st.state = RAWF_FLUSH;
                            next_st.acc_cnt = st.acc_cnt + 16'h0001;
                        end else begin
                            next_st.state = RAWF_IDLE;
                            next_st.drop_cnt = st.drop_cnt + 16'h0001;
                        end
                    end
                end
            end

            RAWF_FLUSH: begin
                // Drain the held bytes; input is stalled meanwhile
                next_st.out_data = st.dline[5];
                next_st.out_valid = 1'b1;
                next_st.out_last = (st.flush_cnt == 3'h1);
                next_st.dline = {st.dline[4:0], 8'h00};
                next_st.flush_cnt = st.flush_cnt - 3'h1;

                if (st.flush_cnt == 3'h1) begin
                    next_st.state = RAWF_IDLE;
                end
            end
            default: begin
                next_st.state = RAWF_IDLE;
            end
        endcase

        // Set wins over a clear in the same cycle
        if (wake_hit) begin
            next_st.wake_rcvd = 1'b1;
        end
    end

    // First transmitted bit of the destination marks multicast
    function automatic logic rx_data_in_first_bit(input logic sof, input logic [7:0] d,
                                                  input logic [7:0] first);
        return sof ? d[0] : first[0];
    endfunction

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            st <= '0;
            st.state <= RAWF_IDLE;
            st.ctrl <= RAWF_CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Holds until next read
    assign reg_rdata_out = st.rd_data;
    assign rx_ready_out = (st.state != RAWF_FLUSH);

    // Data outputs from flops
    assign host_data_out = st.out_data;
    assign host_valid_out = st.out_valid;
    assign host_last_out = st.out_last;

    // Level outputs follow the sticky flag until software clears it
    assign host_irq_out = st.wake_rcvd && st.irq_en;
    assign power_event_output_out = st.wake_rcvd && st.pme_en;

endmodule

// [rtl/rawf_pkg.sv]
// Package of constants and types for the receive address and wake filter
package rawf_pkg;

    // ****************************************************************
    // Register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] RAWF_OFS_MAC_CONTROL = 8'h00;
    localparam logic [7:0] RAWF_OFS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] RAWF_OFS_ADDR_LOW = 8'h08;
    localparam logic [7:0] RAWF_OFS_HASH_HIGH = 8'h0C;
    localparam logic [7:0] RAWF_OFS_HASH_LOW = 8'h10;
    localparam logic [7:0] RAWF_OFS_WAKE_CTRL = 8'h14;
    localparam logic [7:0] RAWF_OFS_WAKE_FILTER = 8'h18;
    localparam logic [7:0] RAWF_OFS_FRAME_STATS = 8'h1C;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int RAWF_BIT_PASS_ALL_MC = 0;
    localparam int RAWF_BIT_PROMISC = 1;
    localparam int RAWF_BIT_INVERSE = 2;
    localparam int RAWF_BIT_HASH_ONLY = 3;
    localparam int RAWF_BIT_HASH_PERFECT = 4;
    localparam int RAWF_BIT_BROADCAST_DISABLE_DIS = 5;
    localparam int RAWF_BIT_WAKE_EN = 0;
    localparam int RAWF_BIT_WAKE_RCVD = 1;
    localparam int RAWF_BIT_IRQ_EN = 2;
    localparam int RAWF_BIT_PME_EN = 3;
    localparam int RAWF_BIT_LOW_POWER = 4;
    localparam int RAWF_BIT_RX_BUSY = 5;
    localparam int RAWF_CMD_ENABLE = 0;
    localparam int RAWF_CMD_MCAST = 3;
    localparam int RAWF_CMD_WORD = 4;
    localparam int RAWF_OFFSET_WORD = 5;
    localparam int RAWF_CRC_WORD = 6;

    // ****************************************************************
    // Sizes, reset values and CRC constants
    // ****************************************************************
    localparam int RAWF_NUM_FILTERS = 4;
    localparam int RAWF_MASK_LEN = 31;
    localparam int RAWF_DA_BYTES = 6;
    localparam logic [8:0] RAWF_IDX_MAX = 9'h1FF;
    localparam logic [8:0] RAWF_IDX_LAST_DA = 9'h005;
    localparam logic [2:0] RAWF_FLUSH_LEN = 3'h6;
    localparam logic [5:0] RAWF_CTRL_RESET = 6'h00;
    localparam logic [31:0] RAWF_CRC32_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] RAWF_CRC32_POLY = 32'hEDB88320;
    localparam logic [15:0] RAWF_CRC16_INIT = 16'hFFFF;
    localparam logic [15:0] RAWF_CRC16_POLY = 16'h8005;

    // Receive sequencing states
    typedef enum logic [3:0] {
        RAWF_IDLE = 4'b0001,
        RAWF_ADDR = 4'b0010,
        RAWF_BODY = 4'b0100,
        RAWF_FLUSH = 4'b1000
    } rawf_state_e;

    // Whole state of the filter
    typedef struct packed {
        rawf_state_e state;
        logic [5:0] ctrl;
        logic [15:0] addr_hi;
        logic [31:0] addr_lo;
        logic [31:0] hash_hi;
        logic [31:0] hash_lo;
        logic wake_en;
        logic wake_rcvd;
        logic irq_en;
        logic pme_en;
        logic [2:0] wptr;
        logic [7:0][31:0] wake_pattern_filter;
        logic [5:0][7:0] dline;
        logic [8:0] idx;
        logic [31:0] hcrc;
        logic [3:0][15:0] wcrc;
        logic keep;
        logic wake;
        logic mcast;
        logic addressed;
        logic [2:0] flush_cnt;
        logic [7:0] out_data;
        logic out_valid;
        logic out_last;
        logic [15:0] acc_cnt;
        logic [15:0] drop_cnt;
        logic [31:0] rd_data;
    } rawf_state_s;

endpackage

// [verification/rawf_filter_chk.sv]
// Port timing checker for the receive address and wake filter
`timescale 1ns/1ns
module rawf_filter_chk
    import rawf_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic rx_valid_in,
    input wire logic rx_eof_in,
    input wire logic rx_ready_out,
    input wire logic host_valid_out,
    input wire logic host_last_out,
    input wire logic host_irq_out,
    input wire logic power_event_output_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // ****************************************************************
    // Assertions and covers
    // ****************************************************************
    chk_flush_length: assert property ($fell(rx_ready_out) |=>
        !rx_ready_out [*5] ##1 rx_ready_out) else $error("Flush not six cycles");
    chk_last_drain: assert property ($fell(rx_ready_out) |->
        ##6 (host_last_out && host_valid_out)) else $error("Last byte not at flush end");
    chk_last_valid: assert property (host_last_out |-> host_valid_out)
        else $error("Last flag without valid byte");
    // Output must follow receive traffic, never appear from nothing
    chk_out_cause: assert property ($rose(host_valid_out) |->
        $past(rx_valid_in) || $past(rx_valid_in, 2)) else $error("Output without input");
    chk_irq_cause: assert property ($rose(host_irq_out) |->
        $past(rx_valid_in && rx_eof_in) || $past(reg_wr_in)) else $error("Irq rose unprompted");
    chk_pme_cause: assert property ($rose(power_event_output_out) |->
        $past(rx_valid_in && rx_eof_in) || $past(reg_wr_in)) else $error("Power event unprompted");
    chk_irq_clear: assert property ($fell(host_irq_out) |-> $past(reg_wr_in))
        else $error("Irq dropped without host write");
    chk_rdata_hold: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
        else $error("Read data moved without read");
    cov_last: cover property (host_last_out);
    cov_irq: cover property ($rose(host_irq_out));
    cov_pme: cover property ($rose(power_event_output_out));
endmodule

bind rawf_filter rawf_filter_chk u_chk (.ref_clk_in, .rst_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .rx_valid_in, .rx_eof_in, .rx_ready_out, .host_valid_out,
    .host_last_out, .host_irq_out, .power_event_output_out);

// [verification/rawf_peer_model.sv]
// Remote station model that sends frames into the receive path
`timescale 1ns/1ns
module rawf_peer_model (
    input wire logic ref_clk_in,
    output logic rx_valid_out,
    output logic [7:0] rx_data_out,
    output logic rx_sof_out,
    output logic rx_eof_out
);
    // Quiet line at time zero
    initial begin
        rx_valid_out = 1'b0;
        rx_data_out = 8'h5A;
        rx_sof_out = 1'b0;
        rx_eof_out = 1'b0;
    end
    // Destination first, byte 0 low bits; payload byte k carries k
    task automatic send(input logic [47:0] da, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge ref_clk_in);
            rx_valid_out <= 1'b1;
            rx_sof_out <= (k == 0);
            rx_eof_out <= (k == n - 1);
            rx_data_out <= (k < 6) ? da[8*k +: 8] : 8'(k);
        end
        @(posedge ref_clk_in);
        rx_valid_out <= 1'b0;
        rx_sof_out <= 1'b0;
        rx_eof_out <= 1'b0;
        rx_data_out <= ~rx_data_out; // Released line must not look like data
    endtask
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the receive address and wake filter
`timescale 1ns/1ns
module tb_top;
    import rawf_pkg::*;
    localparam logic [47:0] ST = 48'h5544_3322_1100;
    localparam logic [47:0] OTH = 48'h5544_3322_1102;
    localparam logic [47:0] MC = 48'h0000_0000_0001;
    localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic low_power_d1_in = 1'b0;
    logic [31:0] reg_rdata_out;
    logic rx_valid_in, rx_sof_in, rx_eof_in, rx_ready_out;
    logic [7:0] rx_data_in, host_data_out;
    logic host_valid_out, host_last_out, host_irq_out, power_event_output_out;
    logic [15:0] exp_acc = 16'h0, exp_drop = 16'h0;
    logic [31:0] n_host = 32'h0, exp_bytes = 32'h0, rv;
    logic [31:0] wv [8];
    logic [47:0] cur_da = 48'h0;
    logic [8:0] exp_b;
    int n_pos = 0, cur_n = 0;
    int err_count = 0, n_checks = 0;

    always #25 ref_clk_in = ~ref_clk_in;

    rawf_filter dut (.ref_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .rx_valid_in, .rx_data_in, .rx_sof_in, .rx_eof_in,
        .rx_ready_out, .low_power_d1_in, .host_data_out, .host_valid_out, .host_last_out,
        .host_irq_out, .power_event_output_out);
    rawf_peer_model u_peer (.ref_clk_in, .rx_valid_out(rx_valid_in),
        .rx_data_out(rx_data_in), .rx_sof_out(rx_sof_in), .rx_eof_out(rx_eof_in));

    // Count delivered bytes; a rejected frame must add none
    always @(posedge ref_clk_in) begin
        if (host_valid_out === 1'b1) begin
            n_host <= n_host + 32'h1;
            exp_b = {n_pos == cur_n - 1, (n_pos < 6) ? cur_da[8*n_pos +: 8] : 8'(n_pos)};
            check({23'h0, host_last_out, host_data_out}, {23'h0, exp_b});
            n_pos <= host_last_out ? 0 : n_pos + 1;
        end
    end
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    // Read data appear in the cycle after the strobe and hold until the next read
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge ref_clk_in);
        d = reg_rdata_out;
    endtask
    // Send a frame, then compare statistics and delivered byte count
    task automatic frame(input logic [47:0] da, input int n, input logic acc);
        cur_da = da;
        cur_n = n;
        u_peer.send(da, n);
        repeat (10) @(posedge ref_clk_in); // Six flush cycles plus margin
        if (acc) begin
            exp_acc++;
            exp_bytes += 32'(n);
        end else begin
            exp_drop++;
        end
        rd(RAWF_OFS_FRAME_STATS, rv);
        check(rv, {exp_drop, exp_acc});
        check(n_host, exp_bytes);
    endtask
    function automatic logic [15:0] crc16(input logic [7:0] d);
        logic [15:0] c;
        c = RAWF_CRC16_INIT;
        for (int i = 7; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? RAWF_CRC16_POLY : 16'h0);
        end
        return c;
    endfunction
    task automatic complete_run;
        $display("Checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge ref_clk_in);
        err_count++;
        complete_run;
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (8) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rd(RAWF_OFS_WAKE_CTRL, rv);
        check(rv, 32'h0);
        rd(8'hFC, rv);
        check(rv, 32'h0); // Unmapped place reads zero
        wr(RAWF_OFS_ADDR_LOW, 32'h3322_1100);
        wr(RAWF_OFS_ADDR_HIGH, 32'h0000_5544);
        wr(RAWF_OFS_HASH_HIGH, 32'hFFFF_FFFF);
        wr(RAWF_OFS_HASH_LOW, 32'hFFFF_FFFF);
        frame(ST, 8, 1'b1);
        frame(OTH, 8, 1'b0);
        frame(MC, 8, 1'b0);
        wr(RAWF_OFS_MAC_CONTROL, 32'h10);
        frame(MC, 8, 1'b1);
        frame(OTH, 8, 1'b0);
        wr(RAWF_OFS_MAC_CONTROL, 32'h18);
        frame(OTH, 8, 1'b1);
        wr(RAWF_OFS_HASH_HIGH, 32'h0);
        wr(RAWF_OFS_HASH_LOW, 32'h0);
        frame(OTH, 8, 1'b0);
        wr(RAWF_OFS_MAC_CONTROL, 32'h04);
        frame(OTH, 8, 1'b1);
        frame(ST, 8, 1'b0);
        wr(RAWF_OFS_MAC_CONTROL, 32'h22);
        frame(BC, 8, 1'b1);
        wr(RAWF_OFS_MAC_CONTROL, 32'h01);
        frame(MC, 8, 1'b1);
        frame(OTH, 8, 1'b0);
        // Filter 0: unicast, offset 13 from the start of the frame, one masked byte
        wv = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0D, {16'h0, crc16(8'h0D)}, 32'h0};
        wr(RAWF_OFS_WAKE_CTRL, 32'h0C);
        for (int i = 0; i < 8; i++) wr(RAWF_OFS_WAKE_FILTER, wv[i]);
        wr(RAWF_OFS_WAKE_CTRL, 32'h0D);
        frame(ST, 16, 1'b0);
        check({31'h0, host_irq_out}, 32'h1);
        check({31'h0, power_event_output_out}, 32'h1);
        rd(RAWF_OFS_WAKE_CTRL, rv);
        check(rv, 32'h0F);
        wr(RAWF_OFS_WAKE_CTRL, 32'h0E);
        rd(RAWF_OFS_WAKE_CTRL, rv);
        check(rv, 32'h0C);
        check({31'h0, host_irq_out}, 32'h0);
        frame(ST, 8, 1'b1);
        @(posedge ref_clk_in);
        low_power_d1_in <= 1'b1;
        frame(ST, 16, 1'b0);
        check({31'h0, host_irq_out}, 32'h1);
        // Multicast-only filter 0
        wv[4] = 32'h9;
        wr(RAWF_OFS_WAKE_CTRL, 32'h0F);
        low_power_d1_in <= 1'b0;
        for (int i = 0; i < 8; i++) wr(RAWF_OFS_WAKE_FILTER, wv[i]);
        frame(ST, 16, 1'b0);
        check({31'h0, host_irq_out}, 32'h0);
        wr(RAWF_OFS_MAC_CONTROL, 32'h20);
        frame(BC, 16, 1'b0);
        check({31'h0, power_event_output_out}, 32'h1);
        complete_run;
    end
endmodule
